/* File: sim/sdb_peer.sv */
// partner: remote serial transceiver, decodes txd and sends on rxd
// assumes per is the bit period in mclk cycles, set by the bench
`timescale 1ns/1ps
module sdb_peer (
	input wire mclk,
	input wire txd,
	input wire nine,
	input int per,
	output logic rxd,
	output logic [8:0] got,
	output logic got_v
);
	integer i;
	integer j;
	// ==========
	// decode: mid-bit samples, got[8] is stop or ninth bit
	initial begin
		rxd = 1'b1;
		got_v = 1'b0;
		forever begin
			@(negedge txd);
			repeat (per / 2) @(posedge mclk);
			for (i = 0; i < 9 + nine; i++) begin
				repeat (per) @(posedge mclk);
				if (i < 9) got[i] = txd;
			end
			got_v <= 1'b1;
			@(posedge mclk);
			got_v <= 1'b0;
		end
	end
	// send one frame; v[8] is stop bit in 8-bit, ninth bit in 9-bit
	task send(input [8:0] v);
		for (j = 0; j < 11 + nine; j++) begin
			rxd = (j == 0) ? 1'b0 : (j < 10) ? v[j-1] : 1'b1;
			repeat (per) @(negedge mclk); // bits change away from the sampling edge
		end
	endtask
endmodule // sdb_peer

/* File: sim/sdb_uart_checker.sv */
// checker: port-level assertions on the serial data buffer
// assumes a bind onto sdb_uart, single mclk domain
`timescale 1ns/1ps
module sdb_chk (
	input wire mclk,
	input wire rst_n,
	input wire [7:0] sfr_addr,
	input wire sfr_rd,
	input wire [7:0] sfr_rdata,
	input wire timer_clock_direct_select,
	input wire [7:0] baud_timer_reload,
	input wire transmit_flag_clear,
	input wire receive_flag_clear,
	input wire transmit_flag,
	input wire receive_flag,
	input wire ninth_receive_bit,
	input wire tx_ready,
	input wire txd
);
	// ==========
	// assertions
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (!rst_n);
	a_rd_other_zero: assert property (sfr_rd && sfr_addr != 8'h99 |=> sfr_rdata == 8'h00)
		else $error("read of other address not zero");
	a_rdata_idle_zero: assert property (!$past(sfr_rd) |-> sfr_rdata == 8'h00)
		else $error("read data shown without a read");
	a_reset_idle: assert property ($rose(rst_n) |-> txd && tx_ready && sfr_rdata == 8'h00)
		else $error("outputs not idle after reset");
	a_start_width: assert property ($fell(txd) && timer_clock_direct_select &&
		baud_timer_reload == 8'hfc |-> !txd [*8])
		else $error("start bit length wrong");
	a_tflag_holds: assert property (transmit_flag && !transmit_flag_clear |=> transmit_flag)
		else $error("transmit flag dropped");
	a_tflag_at_stop: assert property ($rose(transmit_flag) |-> ##[0:1] txd)
		else $error("transmit flag not at stop bit");
	a_rflag_holds: assert property (receive_flag && !receive_flag_clear |=> receive_flag)
		else $error("receive flag dropped");
	a_ninth_with_flag: assert property ($changed(ninth_receive_bit) |-> $rose(receive_flag))
		else $error("ninth bit loaded without flag");
endmodule // sdb_chk
bind sdb_uart sdb_chk u_chk (.mclk(mclk), .rst_n(rst_n), .sfr_addr(sfr_addr), .sfr_rd(sfr_rd),
	.sfr_rdata(sfr_rdata), .timer_clock_direct_select(timer_clock_direct_select),
	.baud_timer_reload(baud_timer_reload), .transmit_flag_clear(transmit_flag_clear),
	.receive_flag_clear(receive_flag_clear), .transmit_flag(transmit_flag),
	.receive_flag(receive_flag), .ninth_receive_bit(ninth_receive_bit), .tx_ready(tx_ready),
	.txd(txd));

/* File: sim/tb_sdb_uart.sv */
// testbench: serial data buffer transmit, receive and baud select
// assumes sdb_uart, sdb_peer and the bound checker are compiled with it
`timescale 1ns/1ps
`define CHK(a, e) chk(a, e)
module tb_sdb_uart;
	logic mclk = 0, rst_n = 0, sfr_wr = 0, sfr_rd = 0, mode = 0, mce = 0, nt = 0, ren = 1;
	logic dsel = 1, ext = 0, tfc = 0, rfc = 0, rd_d = 0, fl = 0, nb = 0;
	logic tflag, rflag, nrb, tx_ready, txd, rxd, got_v;
	logic [1:0] pre = 0;
	logic [7:0] addr = 0, wdata = 0, reload = 8'hfc, rdata, last = 0;
	logic [8:0] got;
	logic [8:0] txq[$];
	logic [8:0] rdq[$];
	logic [11:0] bt[5] = '{12'h808, 12'h060, 12'h210, 12'h580, 12'h780};
	logic [11:0] rxt[7] = '{12'h1a5, 12'h33c, 12'h677, 12'h245, 12'he11, 12'hfe2, 12'ha3c};
	int per = 8, num_errors = 0, checks = 0, k, n;
	sdb_uart dut (.mclk(mclk), .rst_n(rst_n), .sfr_addr(addr), .sfr_wdata(wdata), .sfr_wr(sfr_wr),
		.sfr_rd(sfr_rd), .sfr_rdata(rdata), .frame_mode_select(mode), .multiproc_check_enable(mce),
		.receive_enable(ren), .ninth_transmit_bit(nt), .timer_clock_direct_select(dsel),
		.timer_prescale_select(pre), .baud_timer_reload(reload), .external_osc_clock(ext),
		.transmit_flag_clear(tfc), .receive_flag_clear(rfc), .transmit_flag(tflag),
		.receive_flag(rflag), .ninth_receive_bit(nrb), .tx_ready(tx_ready), .txd(txd), .rxd(rxd));
	sdb_peer u_peer (.mclk(mclk), .txd(txd), .nine(mode), .per(per), .rxd(rxd), .got(got),
		.got_v(got_v));
	// ==========
	// clocks: 25 ns core clock, external clock period of six cycles
	initial forever #12.5 mclk = ~mclk;
	always begin
		repeat (3) @(negedge mclk);
		ext = ~ext;
	end
	task chk(input [8:0] a, input [8:0] e);
		checks++;
		if (a !== e) begin
			num_errors++;
			$display("unexpected at %0t: got %h exp %h", $time, a, e);
		end
	endtask
	task summarize;
		$display("checks %0d num_errors %0d", checks, num_errors);
		if (num_errors == 0 && checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task wr(input [7:0] b);
		@(negedge mclk);
		for (n = 0; n < 4000 && tx_ready !== 1'b1; n++) @(negedge mclk);
		nt = $urandom;
		txq.push_back({mode ? nt : 1'b1, b});
		addr = 8'h99;
		wdata = b;
		sfr_wr = 1;
		@(negedge mclk);
		sfr_wr = 0;
	endtask
	task rd(input [7:0] a, input [7:0] e);
		@(negedge mclk);
		addr = a;
		sfr_rd = 1;
		rdq.push_back(e);
		@(negedge mclk);
		sfr_rd = 0;
	endtask
	// ==========
	// result watcher: oldest note against each read or decoded frame
	always @(posedge mclk) begin
		if (rd_d) `CHK(rdata, rdq.pop_front());
		if (got_v) `CHK(got, txq.pop_front());
		rd_d <= sfr_rd;
	end
	initial begin
		#(80000 * 25); // well above the length of all tests
		num_errors++;
		summarize;
	end
	// ==========
	// main sequence
	initial begin
		k = $urandom(74);
		repeat (8) @(negedge mclk);
		rst_n = 1;
		rd(8'h99, 8'h00);
		rd(8'h98, 8'h00);
		for (k = 0; k < 5; k++) begin
			dsel = bt[k][11];
			pre = bt[k][10:9];
			per = bt[k][8:0];
			mode = k[0];
			reload = (k == 2) ? 8'hfe : 8'hfc; // shorter timer period in one mode
			repeat (3) wr($urandom);
			`CHK(tx_ready, 1'b0);
			for (n = 0; n < 20000 && txq.size() > 0; n++) @(negedge mclk);
			repeat (per) @(negedge mclk);
		end
		`CHK(txq.size() == 0, 1'b1);
		`CHK(tflag, 1'b1);
		tfc = 1;
		@(negedge mclk);
		tfc = 0;
		`CHK(tflag, 1'b0);
		dsel = 1;
		per = 8;
		// receiver off: frame ignored, and the measured bit period settles meanwhile
		ren = 0;
		u_peer.send(9'h1c3);
		repeat (4) @(negedge mclk);
		`CHK(rflag, 1'b0);
		ren = 1;
		rd(8'h99, 8'h00);
		for (k = 0; k < 7; k++) begin
			mode = rxt[k][11];
			mce = rxt[k][10];
			u_peer.send(rxt[k][8:0]);
			repeat (4) @(negedge mclk);
			if (!fl && (!mce || rxt[k][8])) begin
				fl = 1;
				last = rxt[k][7:0];
				nb = rxt[k][8];
			end
			`CHK(rflag, fl);
			`CHK(nrb, nb);
			rd(8'h99, last);
			if (rxt[k][9]) begin
				rfc = 1;
				@(negedge mclk);
				rfc = 0;
				fl = 0;
			end
		end
		summarize;
	end
endmodule // tb_sdb_uart

/* File: src/sdb_baud.v */
// baud timer: clock source select, 8-bit auto-reload timer, divide by two
// assumes external_osc_clock is already synchronised to mclk by the caller
`timescale 1ns/1ps
`include "sdb_regs.vh"
module sdb_baud (
	input wire mclk,
	input wire rst_n,
	input wire timer_clock_direct_select,
	input wire [1:0] timer_prescale_select,
	input wire ext_rise,
	input wire [7:0] baud_timer_reload,
	output reg bit_tick
);
	// ==========================================
	// source select and prescaler
	reg [7:0] pre_cnt;
	reg [7:0] pre_lim;
	reg tmr_tick;
	reg [8:0] tmr;
	reg half;
	wire pre_step;
	assign pre_step = (timer_prescale_select == `SDB_PRE_EXT8) ? ext_rise : 1'b1;
	// divisor for the selected source
	always @* begin
		case (timer_prescale_select)
			`SDB_PRE_DIV12: pre_lim = `SDB_DIV12;
			`SDB_PRE_DIV4: pre_lim = `SDB_DIV4;
			`SDB_PRE_DIV48: pre_lim = `SDB_DIV48;
			default: pre_lim = `SDB_DIV8;
		endcase
	end
	// prescale counter, direct select bypasses it
	always @(posedge mclk) begin
		tmr_tick <= 1'b0;
		if (!rst_n) begin
			pre_cnt <= 8'h00;
		end else if (timer_clock_direct_select) begin
			pre_cnt <= 8'h00;
			tmr_tick <= 1'b1;
		end else if (pre_step) begin
			if (pre_cnt >= pre_lim - 8'h01) begin
				pre_cnt <= 8'h00;
				tmr_tick <= 1'b1;
			end else begin
				pre_cnt <= pre_cnt + 8'h01;
			end
		end
	end
	// ==========================================
	// reload timer, overflow every 256 - reload ticks, halved
	always @(posedge mclk) begin
		bit_tick <= 1'b0;
		if (!rst_n) begin
			tmr <= 9'h000;
			half <= 1'b0;
		end else if (tmr_tick) begin
			if (tmr >= `SDB_RELOAD_TOP - 9'h001) begin
				tmr <= {1'b0, baud_timer_reload};
				half <= ~half;
				bit_tick <= half;
			end else begin
				tmr <= tmr + 9'h001;
			end
		end
	end
endmodule // sdb_baud

/* File: src/sdb_regs.vh */
// register offset, prescale select codes, reset values and timing figures for the serial data buffer
// assumes inclusion by sdb_uart.v and sdb_baud.v
`ifndef SDB_REGS_VH
`define SDB_REGS_VH
`define SDB_DATA_ADDR 8'h99
`define SDB_DATA_RESET 8'h00
`define SDB_PRE_DIV12 2'b00
`define SDB_PRE_DIV4 2'b01
`define SDB_PRE_DIV48 2'b10
`define SDB_PRE_EXT8 2'b11
`define SDB_DIV12 8'd12
`define SDB_DIV4 8'd4
`define SDB_DIV48 8'd48
`define SDB_DIV8 8'd8
`define SDB_RELOAD_TOP 9'd256
`define SDB_OVF_PER_BIT 2'd2
`define SDB_BITS_8 4'd10
`define SDB_BITS_9 4'd11
`endif

/* File: src/sdb_uart.v */
// serial data buffer with transmit shifter and receive latch, 8 or 9 bit frames
// assumes a byte-wide special function register bus on mclk; rx and ext clock are async pins
`timescale 1ns/1ps
`include "sdb_regs.vh"
// Contract
// - one data address reaches a transmit shifter on write, receive latch on read
// - a byte written while tx_ready is high waits in the write buffer, then stays in the transmit shifter until shifted out
// - only a data register write starts a transmission
// - a data read returns the receive latch, never the transmit shifter
// - data register is eight bits, bit 7 msb, clears to zero at reset
// - timer clock: direct bit gives core clock, else prescale picks divider
// - bit rate is timer clock over 256 minus reload, halved
// - 8-bit frame: start, eight data lsb first, stop; stop kept as ninth bit
// - 9-bit frame adds the software ninth bit; received ninth bit kept
// - latch and flag only when flag clear and, if checking, checked bit is one
module sdb_uart (
	input wire mclk,
	input wire rst_n,
	input wire [7:0] sfr_addr,
	input wire [7:0] sfr_wdata,
	input wire sfr_wr,
	input wire sfr_rd,
	output reg [7:0] sfr_rdata,
	input wire frame_mode_select,
	input wire multiproc_check_enable,
	input wire receive_enable,
	input wire ninth_transmit_bit,
	input wire timer_clock_direct_select,
	input wire [1:0] timer_prescale_select,
	input wire [7:0] baud_timer_reload,
	input wire external_osc_clock,
	input wire transmit_flag_clear,
	input wire receive_flag_clear,
	output reg transmit_flag,
	output reg receive_flag,
	output reg ninth_receive_bit,
	output wire tx_ready,
	output reg txd,
	input wire rxd
);
	localparam ST_IDLE = 3'b001;
	localparam ST_SEND = 3'b010;
	localparam ST_WAIT = 3'b100;
	// ==========================================
	// pin synchronisers
	reg rx_s1, rx_s2, ext_s1, ext_s2, ext_s3;
	always @(posedge mclk) begin
		if (!rst_n) begin
			rx_s1 <= 1'b1;
			rx_s2 <= 1'b1;
			ext_s1 <= 1'b0;
			ext_s2 <= 1'b0;
			ext_s3 <= 1'b0;
		end else begin
			rx_s1 <= rxd;
			rx_s2 <= rx_s1;
			ext_s1 <= external_osc_clock;
			ext_s2 <= ext_s1;
			ext_s3 <= ext_s2;
		end
	end
	wire ext_rise;
	assign ext_rise = ext_s2 & ~ext_s3;
	// ==========================================
	// baud clock
	wire bit_tick;
	sdb_baud u_baud (
		.mclk(mclk),
		.rst_n(rst_n),
		.timer_clock_direct_select(timer_clock_direct_select),
		.timer_prescale_select(timer_prescale_select),
		.ext_rise(ext_rise),
		.baud_timer_reload(baud_timer_reload),
		.bit_tick(bit_tick)
	);
	// write strobe aimed at the data buffer address
	wire wr_hit;
	assign wr_hit = sfr_wr && (sfr_addr == `SDB_DATA_ADDR);
	// ==========================================
	// two-entry write buffer in front of the shifter
	reg [7:0] buf_d0, buf_d1;
	reg buf_n0, buf_n1; // ninth bit captured with each byte
	reg [1:0] buf_cnt;
	wire buf_pop;
	assign tx_ready = (buf_cnt != 2'd2);
	always @(posedge mclk) begin
		if (!rst_n) begin
			buf_cnt <= 2'd0;
			buf_d0 <= `SDB_DATA_RESET;
			buf_d1 <= `SDB_DATA_RESET;
			buf_n0 <= 1'b0;
			buf_n1 <= 1'b0;
		end else begin
			if (buf_pop) begin
				buf_d0 <= buf_d1;
				buf_n0 <= buf_n1;
			end
			if (wr_hit && tx_ready) begin
				if ((buf_cnt == 2'd0) || (buf_cnt == 2'd1 && buf_pop)) begin
					buf_d0 <= sfr_wdata;
					buf_n0 <= ninth_transmit_bit;
				end else begin
					buf_d1 <= sfr_wdata;
					buf_n1 <= ninth_transmit_bit;
				end
			end
			case ({wr_hit && tx_ready, buf_pop})
				2'b10: buf_cnt <= buf_cnt + 2'd1;
				2'b01: buf_cnt <= buf_cnt - 2'd1;
				default: buf_cnt <= buf_cnt;
			endcase
		end
	end
	// ==========================================
	// transmitter
	reg [2:0] tx_st;
	reg [10:0] tx_sh;
	reg [3:0] tx_left;
	assign buf_pop = (tx_st == ST_IDLE) && (buf_cnt != 2'd0);
	always @(posedge mclk) begin
		if (!rst_n) begin
			tx_st <= ST_IDLE;
			tx_sh <= 11'h7ff;
			tx_left <= 4'd0;
			txd <= 1'b1;
			transmit_flag <= 1'b0;
		end else begin
			if (transmit_flag_clear)
				transmit_flag <= 1'b0;
			case (tx_st)
				ST_IDLE: begin
					if (buf_pop) begin
						// stop, optional ninth, data lsb first, start
						if (frame_mode_select) begin
							tx_sh <= {1'b1, buf_n0, buf_d0, 1'b0};
							tx_left <= `SDB_BITS_9;
						end else begin
							tx_sh <= {2'b11, buf_d0, 1'b0};
							tx_left <= `SDB_BITS_8;
						end
						tx_st <= ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (bit_tick) begin
						txd <= tx_sh[0];
						tx_st <= ST_SEND;
					end
				end
				ST_SEND: begin
					if (bit_tick) begin
						tx_sh <= {1'b1, tx_sh[10:1]};
						tx_left <= tx_left - 4'd1;
						txd <= tx_sh[1];
						if (tx_left == 4'd2)
							transmit_flag <= 1'b1; // stop bit begins, set wins over clear
						if (tx_left == 4'd1) begin
							txd <= 1'b1;
							tx_st <= ST_IDLE;
						end
					end
				end
				default: tx_st <= ST_IDLE;
			endcase
		end
	end
	// ==========================================
	// receiver: sample at mid-bit using sub-tick count of a bit period
	reg [7:0] rx_latch;
	reg [9:0] rx_sh;
	reg [3:0] rx_left;
	reg rx_busy;
	reg [15:0] rx_cnt;
	reg [15:0] bit_per;
	reg [15:0] per_run;
	// measure bit period in mclk cycles from the baud tick
	always @(posedge mclk) begin
		if (!rst_n) begin
			per_run <= 16'h0000;
			bit_per <= 16'h0000;
		end else if (bit_tick) begin
			bit_per <= per_run + 16'h0001;
			per_run <= 16'h0000;
		end else begin
			per_run <= per_run + 16'h0001;
		end
	end
	wire [3:0] rx_total;
	wire rx_check;
	wire rx_ok;
	assign rx_total = frame_mode_select ? `SDB_BITS_9 : `SDB_BITS_8;
	// checked bit: ninth data bit in 9-bit mode, stop bit in 8-bit mode
	// at the last sample the earlier samples sit in rx_sh, newest at bit 9
	assign rx_check = frame_mode_select ? rx_sh[9] : rx_s2;
	assign rx_ok = !receive_flag && (!multiproc_check_enable || rx_check);
	always @(posedge mclk) begin
		if (!rst_n) begin
			rx_busy <= 1'b0;
			rx_cnt <= 16'h0000;
			rx_left <= 4'd0;
			rx_sh <= 10'h000;
			rx_latch <= `SDB_DATA_RESET;
			receive_flag <= 1'b0;
			ninth_receive_bit <= 1'b0;
		end else begin
			if (receive_flag_clear)
				receive_flag <= 1'b0;
			if (!rx_busy) begin
				if (receive_enable && !rx_s2 && bit_per != 16'h0000) begin
					rx_busy <= 1'b1;
					rx_cnt <= {1'b0, bit_per[15:1]};
					rx_left <= rx_total;
				end
			end else if (rx_cnt != 16'h0000) begin
				rx_cnt <= rx_cnt - 16'h0001;
			end else begin
				rx_cnt <= bit_per - 16'h0001;
				rx_left <= rx_left - 4'd1;
				rx_sh <= {rx_s2, rx_sh[9:1]};
				if (rx_left == rx_total && rx_s2)
					rx_busy <= 1'b0; // false start
				if (rx_left == 4'd1) begin
					rx_busy <= 1'b0;
					if (rx_ok) begin
						if (frame_mode_select) begin
							rx_latch <= rx_sh[8:1];
							ninth_receive_bit <= rx_sh[9];
						end else begin
							rx_latch <= rx_sh[9:2];
							ninth_receive_bit <= rx_s2;
						end
						receive_flag <= 1'b1; // set wins over clear
					end
				end
			end
		end
	end
	// ==========================================
	// read port returns the receive latch only
	always @(posedge mclk) begin
		if (!rst_n)
			sfr_rdata <= 8'h00;
		else if (sfr_rd && sfr_addr == `SDB_DATA_ADDR)
			sfr_rdata <= rx_latch;
		else
			sfr_rdata <= 8'h00;
	end
endmodule // sdb_uart
